/* File: rtl/bit_sync.sv */
// two flip-flop synchroniser for levels, also used as reset release
// assumes the source is stable for longer than two destination clocks
module bit_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,   // destination clock
    input  wire logic         rst_n, // async reset, active low
    input  wire logic [W-1:0] din,   // level from another domain
    output logic      [W-1:0] dout   // synchronised level
);

    logic [W-1:0] meta_r;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_r <= '0;
            dout   <= '0;
        end else begin
            meta_r <= din;
            dout   <= meta_r;
        end
    end

endmodule

/* File: rtl/eeprom_host_if.sv */
// eeprom host interface: register side on clk, serial engine on linkClk
// assumes pads resolve the data wire from gpioFiveOe; chip select is a gpio
// How it works
// (RULE_01) select 1 puts serial clock on gpio four, data on gpio five
// (RULE_02) transmit code sends the data register byte, busy held until done
// (RULE_03) two-pin completion interrupt fires when busy falls
// (RULE_04) receive code clocks a byte in, sends ack, stores it
// (RULE_05) two-pin clock toggles at 78 kHz, then holds high
// (RULE_06) unlisted code does nothing and sets the error bit 7
// (RULE_07) bit 6 shows busy in both modes
// (RULE_08) bit 5 low when the eeprom acknowledged our byte
// (RULE_09) bit 4 low when we sent an acknowledge
// (RULE_10) no-op stops the serial clock, otherwise it keeps toggling
// (RULE_11) codes 1001 and 0101 make start and stop conditions
// (RULE_12) code 0110 receives a last byte without acknowledge
// (RULE_13) select 3 runs the three-wire port at 500 kHz
// (RULE_14) software uses three-wire only with cpu divider 000
// (RULE_15) each three-wire control write moves up to 8 bits
// (RULE_16) count gives clocks 0..8; reads right-justify msb first
// (RULE_17) writes shift out of the data register msb
// (RULE_18) count zero issues no clocks, data line follows release bit
// (RULE_19) release bit floats data right after the last rising clock
// (RULE_20) wait-for-ready with release delays busy fall until data rises
// (RULE_21) software raises chip select before and lowers it after
// (RULE_22) after a read software writes count zero, release clear
// (RULE_23) two-pin data line released whenever not driving low
module eeprom_host_if #(
    parameter int LINK_HZ = 33_333_333,
    parameter int HALF_W  = 12
) (
    input  wire logic       clk,              // register clock
    input  wire logic       rst_n,            // async reset, active low
    input  wire logic       linkClk,          // serial engine clock
    input  wire logic       ctrlWrEn,         // control register write strobe
    input  wire logic       dataWrEn,         // data register write strobe
    input  wire logic [7:0] wrData,           // write data
    output logic      [7:0] ctrlRdData,       // control register read value
    output logic      [7:0] dataRdData,       // data register read value
    input  wire logic [1:0] eepromPortSelect, // port select field
    output logic            eepromDoneIrq,    // pulse when busy falls
    output logic            gpioFourOut,      // serial clock
    output logic            gpioFourOe,       // serial clock enable
    input  wire logic       gpioFiveIn,       // data pin level
    output logic            gpioFiveOut,      // data pin drive value
    output logic            gpioFiveOe        // data pin drive enable
);

    // --------------------------------------------------------------
    // resets and timing
    // --------------------------------------------------------------
    localparam logic [HALF_W-1:0] TWO_HALF =
        HALF_W'(LINK_HZ / (2 * eeprom_if_pkg::TWO_PIN_HZ));
    localparam logic [HALF_W-1:0] THREE_HALF =
        HALF_W'(LINK_HZ / (2 * eeprom_if_pkg::THREE_WIRE_HZ));

    logic rstSyncN;
    logic linkRstN;

    bit_sync #(.W(1)) uRstClk (
        .clk   (clk),
        .rst_n (rst_n),
        .din   (1'b1),
        .dout  (rstSyncN)
    );

    bit_sync #(.W(1)) uRstLink (
        .clk   (linkClk),
        .rst_n (rst_n),
        .din   (1'b1),
        .dout  (linkRstN)
    );

    // --------------------------------------------------------------
    // register side
    // --------------------------------------------------------------
    eeprom_if_pkg::link_req_s pay_r;
    eeprom_if_pkg::link_rsp_s rsp;
    logic       reqTgl_r;
    logic       doneSeen_r;
    logic       doneSync;
    logic       doneTgl_r;
    logic       busy_r;
    logic       err_r;
    logic       rxAckN_r;
    logic       txAckN_r;
    logic       irq_r;
    logic [7:0] data_r;
    logic       twoSel;
    logic       threeSel;
    logic       cmdLegal;
    logic       launch;
    logic       illegal;
    logic       doneEvt;

    assign twoSel   = eepromPortSelect == eeprom_if_pkg::PORT_TWO_PIN;
    assign threeSel = eepromPortSelect == eeprom_if_pkg::PORT_THREE_WIRE;
    assign cmdLegal = wrData[3:0] inside {eeprom_if_pkg::CMD_NOOP,
        eeprom_if_pkg::CMD_RECV, eeprom_if_pkg::CMD_XMIT, eeprom_if_pkg::CMD_STOP,
        eeprom_if_pkg::CMD_RECV_END, eeprom_if_pkg::CMD_START};
    // writes during busy are dropped: the payload must stay still while it crosses
    assign launch   = ctrlWrEn && !busy_r && ((twoSel && cmdLegal) || threeSel); // RULE_15
    assign illegal  = ctrlWrEn && !busy_r && twoSel && !cmdLegal; // RULE_06
    assign doneEvt  = doneSync != doneSeen_r;

    bit_sync #(.W(1)) uDoneSync (
        .clk   (clk),
        .rst_n (rstSyncN),
        .din   (doneTgl_r),
        .dout  (doneSync)
    );

    always_ff @(posedge clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            pay_r      <= '0;
            reqTgl_r   <= 1'b0;
            doneSeen_r <= 1'b0;
            busy_r     <= 1'b0;
            irq_r      <= 1'b0;
        end else begin
            if (launch) begin
                pay_r    <= '{mode: eepromPortSelect, ctrl: wrData, data: data_r};
                reqTgl_r <= ~reqTgl_r;
            end
            doneSeen_r <= doneSync;
            busy_r     <= launch || (busy_r && !doneEvt); // RULE_02 RULE_07
            irq_r      <= doneEvt; // RULE_03
        end
    end

    always_ff @(posedge clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            err_r    <= eeprom_if_pkg::ERR_RST;
            rxAckN_r <= eeprom_if_pkg::ACKN_RST;
            txAckN_r <= eeprom_if_pkg::ACKN_RST;
            data_r   <= eeprom_if_pkg::DATA_RST;
        end else begin
            if (illegal) begin
                err_r <= 1'b1; // RULE_06
            end else if (launch) begin
                err_r <= 1'b0;
            end
            if (doneEvt) begin
                rxAckN_r <= rsp.rxAckN; // RULE_08
                txAckN_r <= rsp.txAckN; // RULE_09
                data_r   <= rsp.data;   // RULE_04 RULE_16
            end else if (dataWrEn && !busy_r) begin
                data_r <= wrData;
            end
        end
    end

    assign ctrlRdData    = threeSel ? {1'b0, busy_r, 6'h00}
                         : {err_r, busy_r, rxAckN_r, txAckN_r, 4'h0}; // RULE_07
    assign dataRdData    = data_r;
    assign eepromDoneIrq = irq_r;

    // --------------------------------------------------------------
    // serial engine on the link clock
    // --------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE, ST_LOAD, ST_START, ST_STOP, ST_SHIFT, ST_WAIT, ST_DONE
    } eng_state_e;

    eng_state_e st_r, st_nxt;
    eeprom_if_pkg::link_req_s lreq_r, lreq_nxt;
    logic [3:0] bit_r, bit_nxt, total_r, total_nxt;
    logic [7:0] shift_r, shift_nxt, rx_r, rx_nxt;
    logic sck_r, sck_nxt, sdaOut_r, sdaOut_nxt, sdaOe_r, sdaOe_nxt;
    logic clkRun_r, clkRun_nxt, ackN_r, ackN_nxt, txAck_r, txAck_nxt;
    logic reqSeen_r, reqSeen_nxt, doneTgl_nxt, sdaPrev_r;
    logic reqSync, sdaSync, tick, restart, readyRise, lastBit;
    logic twoPin, isRead, isTx, release_data_line, wait_for_ready;
    logic [3:0] cmd, cnt, nextBit;
    logic [HALF_W-1:0] half;

    bit_sync #(.W(2)) uLinkSync (
        .clk   (linkClk),
        .rst_n (linkRstN),
        .din   ({reqTgl_r, gpioFiveIn}),
        .dout  ({reqSync, sdaSync})
    );

    assign twoPin    = lreq_r.mode == eeprom_if_pkg::PORT_TWO_PIN;
    assign cmd       = lreq_r.ctrl[3:0];
    assign release_data_line       = lreq_r.ctrl[eeprom_if_pkg::HIZ_BIT];
    assign wait_for_ready       = lreq_r.ctrl[eeprom_if_pkg::WFR_BIT] && release_data_line; // RULE_20
    assign cnt       = lreq_r.ctrl[eeprom_if_pkg::CNT_MSB:0];
    assign isRead    = twoPin ? (cmd == eeprom_if_pkg::CMD_RECV ||
                                 cmd == eeprom_if_pkg::CMD_RECV_END)
                              : lreq_r.ctrl[eeprom_if_pkg::RD_BIT];
    assign isTx      = twoPin ? cmd == eeprom_if_pkg::CMD_XMIT : !isRead;
    assign half      = twoPin ? TWO_HALF : THREE_HALF; // RULE_05 RULE_13
    assign lastBit   = bit_r == total_r - 4'h1;
    assign nextBit   = bit_r + 4'h1;
    assign readyRise = sdaSync && !sdaPrev_r;
    assign rsp       = '{data: isRead ? rx_r : lreq_r.data,
                         rxAckN: ackN_r, txAckN: txAck_r};

    tick_gen #(.W(HALF_W)) uTick (
        .clk     (linkClk),
        .rst_n   (linkRstN),
        .restart (restart),
        .half    (half),
        .tick    (tick)
    );

    always_comb begin
        st_nxt      = st_r;
        lreq_nxt    = lreq_r;
        bit_nxt     = bit_r;
        total_nxt   = total_r;
        shift_nxt   = shift_r;
        rx_nxt      = rx_r;
        sck_nxt     = sck_r;
        sdaOut_nxt  = sdaOut_r;
        sdaOe_nxt   = sdaOe_r;
        clkRun_nxt  = clkRun_r;
        ackN_nxt    = ackN_r;
        txAck_nxt   = txAck_r;
        reqSeen_nxt = reqSeen_r;
        doneTgl_nxt = doneTgl_r;
        restart     = 1'b0;
        unique case (st_r)
            ST_IDLE: begin
                if (reqSync != reqSeen_r) begin
                    reqSeen_nxt = reqSync;
                    lreq_nxt    = pay_r;
                    st_nxt      = ST_LOAD;
                end else if (clkRun_r && tick) begin
                    sck_nxt = ~sck_r; // RULE_10
                end
            end
            ST_LOAD: begin
                restart   = 1'b1;
                bit_nxt   = 4'h0;
                shift_nxt = lreq_r.data;
                rx_nxt    = 8'h00;
                if (twoPin) begin
                    sdaOut_nxt = 1'b0; // RULE_23
                    clkRun_nxt = 1'b1;
                    unique case (cmd)
                        eeprom_if_pkg::CMD_NOOP: begin
                            clkRun_nxt = 1'b0; // RULE_10
                            sck_nxt    = 1'b1;
                            st_nxt     = ST_DONE;
                        end
                        eeprom_if_pkg::CMD_START: begin
                            sck_nxt   = 1'b1;
                            sdaOe_nxt = 1'b0;
                            st_nxt    = ST_START; // RULE_11
                        end
                        eeprom_if_pkg::CMD_STOP: begin
                            sck_nxt   = 1'b0;
                            sdaOe_nxt = 1'b1;
                            st_nxt    = ST_STOP; // RULE_11
                        end
                        default: begin
                            // transmit, receive and last receive share one frame
                            total_nxt = eeprom_if_pkg::FRAME_BITS;
                            sck_nxt   = 1'b0;
                            sdaOe_nxt = isTx && !lreq_r.data[7]; // RULE_02 RULE_23
                            st_nxt    = ST_SHIFT;
                        end
                    endcase
                end else begin
                    clkRun_nxt = 1'b0; // RULE_13
                    total_nxt = (cnt > eeprom_if_pkg::MAX_BITS) ? eeprom_if_pkg::MAX_BITS
                                                               : cnt; // RULE_16
                    if (cnt == 4'h0) begin
                        sdaOe_nxt = !release_data_line; // RULE_18
                        st_nxt    = wait_for_ready ? ST_WAIT : ST_DONE;
                    end else begin
                        sck_nxt    = 1'b0;
                        sdaOe_nxt  = !isRead;
                        sdaOut_nxt = lreq_r.data[7]; // RULE_17
                        st_nxt     = ST_SHIFT;
                    end
                end
            end
            ST_START: begin
                if (tick) begin
                    if (bit_r == 4'h0) begin
                        sdaOe_nxt = 1'b1; // RULE_11
                        bit_nxt   = nextBit;
                    end else begin
                        st_nxt = ST_DONE;
                    end
                end
            end
            ST_STOP: begin
                if (tick) begin
                    bit_nxt = nextBit;
                    if (bit_r == 4'h0) begin
                        sck_nxt = 1'b1;
                    end else if (bit_r == 4'h1) begin
                        sdaOe_nxt = 1'b0; // RULE_11
                    end else begin
                        st_nxt = ST_DONE;
                    end
                end
            end
            ST_SHIFT: begin
                if (tick && !sck_r) begin
                    sck_nxt = 1'b1;
                    if (twoPin && bit_r == eeprom_if_pkg::ACK_SLOT) begin
                        ackN_nxt = isTx ? sdaSync : ackN_r; // RULE_08
                    end else if (isRead) begin
                        rx_nxt = {rx_r[6:0], sdaSync}; // RULE_04 RULE_16
                    end
                    if (!twoPin && lastBit && release_data_line) begin
                        sdaOe_nxt = 1'b0; // RULE_19
                    end
                end else if (tick && lastBit) begin
                    if (!twoPin) begin
                        sck_nxt   = 1'b0;
                        sdaOe_nxt = !release_data_line;
                        st_nxt    = wait_for_ready ? ST_WAIT : ST_DONE; // RULE_20
                    end else begin
                        st_nxt = ST_DONE; // RULE_05
                    end
                end else if (tick) begin
                    sck_nxt    = 1'b0;
                    bit_nxt    = nextBit;
                    shift_nxt  = {shift_r[6:0], 1'b0};
                    sdaOut_nxt = twoPin ? 1'b0 : shift_r[6]; // RULE_17
                    if (twoPin && nextBit == eeprom_if_pkg::ACK_SLOT) begin
                        sdaOe_nxt = cmd == eeprom_if_pkg::CMD_RECV; // RULE_04 RULE_12
                        txAck_nxt = isRead ? cmd != eeprom_if_pkg::CMD_RECV
                                           : txAck_r; // RULE_09
                    end else if (twoPin) begin
                        sdaOe_nxt = isTx && !shift_r[6]; // RULE_23
                    end
                end
            end
            ST_WAIT: begin
                if (readyRise) begin
                    st_nxt = ST_DONE; // RULE_20
                end
            end
            ST_DONE: begin
                doneTgl_nxt = ~doneTgl_r;
                st_nxt      = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge linkClk or negedge linkRstN) begin
        if (!linkRstN) begin
            st_r <= ST_IDLE;
            {lreq_r, bit_r, total_r, shift_r, rx_r} <= '0;
            {sck_r, sdaOut_r, sdaOe_r, clkRun_r} <= 4'h8;
            {ackN_r, txAck_r} <= {eeprom_if_pkg::ACKN_RST, eeprom_if_pkg::ACKN_RST};
            {reqSeen_r, doneTgl_r, sdaPrev_r} <= 3'h0;
        end else begin
            st_r <= st_nxt;
            {lreq_r, bit_r, total_r, shift_r, rx_r} <=
                {lreq_nxt, bit_nxt, total_nxt, shift_nxt, rx_nxt};
            {sck_r, sdaOut_r, sdaOe_r, clkRun_r} <=
                {sck_nxt, sdaOut_nxt, sdaOe_nxt, clkRun_nxt};
            {ackN_r, txAck_r} <= {ackN_nxt, txAck_nxt};
            {reqSeen_r, doneTgl_r, sdaPrev_r} <= {reqSeen_nxt, doneTgl_nxt, sdaSync};
        end
    end

    // --------------------------------------------------------------
    // pins
    // --------------------------------------------------------------
    assign gpioFourOut = sck_r;                // RULE_01 RULE_13
    assign gpioFourOe  = twoSel || threeSel;   // RULE_01
    assign gpioFiveOut = sdaOut_r;
    assign gpioFiveOe  = (twoSel || threeSel) && sdaOe_r;

    // --------------------------------------------------------------
    // assertions
    // --------------------------------------------------------------
    sequence s_xmit_launch;
        launch && wrData[3:0] == eeprom_if_pkg::CMD_XMIT && twoSel;
    endsequence

    property p_xmit_busy;
        @(posedge clk) disable iff (!rstSyncN)
        s_xmit_launch |=> busy_r [*3];
    endproperty
    a_xmit_busy: assert property (p_xmit_busy) else $error("busy not held on transmit"); // RULE_02

    property p_irq_on_fall;
        @(posedge clk) disable iff (!rstSyncN)
        $fell(busy_r) |-> eepromDoneIrq;
    endproperty
    a_irq_on_fall: assert property (p_irq_on_fall) else $error("no irq at busy fall"); // RULE_03

    property p_illegal_err;
        @(posedge clk) disable iff (!rstSyncN)
        illegal |=> ctrlRdData[eeprom_if_pkg::ERR_BIT] && !busy_r;
    endproperty
    a_illegal_err: assert property (p_illegal_err) else $error("illegal code not flagged"); // RULE_06

    property p_busy_bit;
        @(posedge clk) disable iff (!rstSyncN)
        launch |=> ctrlRdData[eeprom_if_pkg::BUSY_BIT];
    endproperty
    a_busy_bit: assert property (p_busy_bit) else $error("busy bit not shown"); // RULE_07

    property p_rxack_load;
        @(posedge clk) disable iff (!rstSyncN)
        doneEvt |=> rxAckN_r == $past(rsp.rxAckN) && txAckN_r == $past(rsp.txAckN);
    endproperty
    a_rxack_load: assert property (p_rxack_load) else $error("ack flags not loaded"); // RULE_08

    property p_open_drain;
        @(posedge clk) disable iff (!rstSyncN)
        twoSel && gpioFiveOe |-> !gpioFiveOut;
    endproperty
    a_open_drain: assert property (p_open_drain) else $error("data driven high"); // RULE_23

    property p_clock_held;
        @(posedge linkClk) disable iff (!linkRstN)
        st_r == ST_IDLE && !clkRun_r && twoPin |-> sck_r;
    endproperty
    a_clock_held: assert property (p_clock_held) else $error("stopped clock not high"); // RULE_05

    property p_zero_count;
        @(posedge linkClk) disable iff (!linkRstN)
        st_r == ST_LOAD && !twoPin && cnt == 4'h0 |=> sdaOe_r == !release_data_line && st_r != ST_SHIFT;
    endproperty
    a_zero_count: assert property (p_zero_count) else $error("zero count misbehaves"); // RULE_18

    property p_release_last;
        @(posedge linkClk) disable iff (!linkRstN)
        st_r == ST_SHIFT && !twoPin && tick && !sck_r && lastBit && release_data_line |=> !sdaOe_r && sck_r;
    endproperty
    a_release_last: assert property (p_release_last) else $error("data not released"); // RULE_19

    property p_wait_ready;
        @(posedge linkClk) disable iff (!linkRstN)
        st_r == ST_WAIT && !readyRise |=> st_r == ST_WAIT;
    endproperty
    a_wait_ready: assert property (p_wait_ready) else $error("busy fell before ready"); // RULE_20

endmodule

/* File: rtl/eeprom_if_pkg.sv */
// constants, field layout and crossing payloads of the eeprom host interface
// assumes a single 8-bit control and data register pair reached by strobes
package eeprom_if_pkg;

    // --------------------------------------------------------------
    // port select and command codes
    // --------------------------------------------------------------
    localparam logic [1:0] PORT_TWO_PIN    = 2'h1;
    localparam logic [1:0] PORT_THREE_WIRE = 2'h3;

    localparam logic [3:0] CMD_NOOP     = 4'h0;
    localparam logic [3:0] CMD_RECV     = 4'h2;
    localparam logic [3:0] CMD_XMIT     = 4'h3;
    localparam logic [3:0] CMD_STOP     = 4'h5;
    localparam logic [3:0] CMD_RECV_END = 4'h6;
    localparam logic [3:0] CMD_START    = 4'h9;

    // --------------------------------------------------------------
    // control register bit positions
    // --------------------------------------------------------------
    localparam int ERR_BIT   = 7;
    localparam int BUSY_BIT  = 6;
    localparam int RXACK_BIT = 5;
    localparam int TXACK_BIT = 4;
    localparam int WFR_BIT   = 7;
    localparam int HIZ_BIT   = 5;
    localparam int RD_BIT    = 4;
    localparam int CNT_MSB   = 3;

    localparam logic [3:0] MAX_BITS   = 4'h8;
    localparam logic [3:0] FRAME_BITS = 4'h9;
    localparam logic [3:0] ACK_SLOT   = 4'h8;

    // --------------------------------------------------------------
    // reset values and serial rates
    // --------------------------------------------------------------
    localparam logic       ERR_RST  = 1'h0;
    localparam logic       ACKN_RST = 1'h1;
    localparam logic [7:0] DATA_RST = 8'h00;

    localparam int TWO_PIN_HZ    = 78000;
    localparam int THREE_WIRE_HZ = 500000;

    typedef struct packed {
        logic [1:0] mode;
        logic [7:0] ctrl;
        logic [7:0] data;
    } link_req_s;

    typedef struct packed {
        logic [7:0] data;
        logic       rxAckN;
        logic       txAckN;
    } link_rsp_s;

endpackage

/* File: rtl/tick_gen.sv */
// half-period tick for the serial clock, restartable at a command start
// assumes half is at least one
module tick_gen #(
    parameter int W = 12
) (
    input  wire logic         clk,     // link clock
    input  wire logic         rst_n,   // link reset, active low
    input  wire logic         restart, // reload so the first half is whole
    input  wire logic [W-1:0] half,    // cycles per half period
    output logic              tick     // one-cycle pulse per half period
);

    logic [W-1:0] cnt_r;
    logic [W-1:0] cnt_nxt;
    logic         reload;

    assign tick    = (cnt_r == '0) && !restart;
    assign reload  = restart || (cnt_r == '0);
    assign cnt_nxt = reload ? half - W'(1) : cnt_r - W'(1);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

endmodule

/* File: testbench/eeprom_model.sv */
// behavioural serial eeprom facing the clock and data pins
// assumes sync pulses with every command so slot counting restarts
module eeprom_model (
    input  wire logic       sck,     // serial clock
    input  wire logic       sdaOut,  // device data value
    input  wire logic       sdaOe,   // device data enable
    input  wire logic       sync,    // command strobe
    input  wire logic       reading, // return txByte in slots 0..7
    input  wire logic       ackEn,   // acknowledge a written byte
    input  wire logic [7:0] txByte,  // byte to return
    input  wire logic       hold,    // busy eeprom holds data low
    output logic            sdaIn,   // resolved wire level
    output logic      [8:0] sh       // bits seen at rising clock
);
    timeunit 1ns;
    timeprecision 100ps;
    // ------------------------------------------------------------
    // wire with pull-up, changes on the falling clock
    // ------------------------------------------------------------
    logic [3:0] n      = 4'h0;
    logic       drvLow = 1'b0;
    initial sh = 9'h000;
    assign sdaIn = (sdaOe ? sdaOut : 1'b1) & !drvLow & !hold;
    always @(negedge sck or posedge sync) begin
        if (sync) begin
            n <= 4'h0;
            drvLow <= 1'b0;
        end else begin
            drvLow <= reading ? (n < 4'h8 && !txByte[4'h7 - n]) : (ackEn && n == 4'h8);
            n <= n + 4'h1;
        end
    end
    always @(posedge sck or posedge sync) begin
        if (sync) sh <= 9'h000;
        else sh <= {sh[7:0], sdaIn};
    end
endmodule

/* File: testbench/tb_top.sv */
// register-level test of the eeprom host interface
// assumes the eeprom model on the data pin and a free link clock
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    // ------------------------------------------------------------
    // clocks, design and partner
    // ------------------------------------------------------------
    logic clk = 0, rst_n = 0, linkClk = 0, ctrlWrEn = 0, dataWrEn = 0, rd = 0, ack = 0;
    logic [7:0] wrData = 8'h00, txByte = 8'h00, ctrlRd, dataRd;
    logic [1:0] sel = 2'h1;
    logic [8:0] sh;
    logic irq, sck, sckOe, sdaIn, sdaOut, sdaOe, hold = 0;
    int mismatches = 0, compares = 0, cyc = 0, irqs = 0, i0, n;
    initial forever #5 clk = ~clk;
    initial begin
        #7;
        forever #15 linkClk = ~linkClk;
    end
    eeprom_host_if #(.LINK_HZ(8_000_000)) u_eeprom_host_if (.clk(clk), .rst_n(rst_n),
        .linkClk(linkClk), .ctrlWrEn(ctrlWrEn), .dataWrEn(dataWrEn), .wrData(wrData),
        .ctrlRdData(ctrlRd), .dataRdData(dataRd), .eepromPortSelect(sel),
        .eepromDoneIrq(irq), .gpioFourOut(sck), .gpioFourOe(sckOe), .gpioFiveIn(sdaIn),
        .gpioFiveOut(sdaOut), .gpioFiveOe(sdaOe));
    eeprom_model u_eeprom_model (.sck(sck), .sdaOut(sdaOut), .sdaOe(sdaOe), .sync(ctrlWrEn),
        .reading(rd), .ackEn(ack), .txByte(txByte), .hold(hold), .sdaIn(sdaIn), .sh(sh));
    always @(posedge clk) begin
        cyc++;
        if (irq === 1'b1) irqs++;
        if (cyc == 60000) begin
            mismatches++;
            report_and_stop();
        end
    end
    // ------------------------------------------------------------
    // access tasks
    // ------------------------------------------------------------
    task chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task report_and_stop;
        if (mismatches == 0 && compares > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task wr(input logic ctrl, input logic [7:0] v);
        @(posedge clk);
        #1 {ctrlWrEn, dataWrEn, wrData} = {ctrl, !ctrl, v};
        @(posedge clk);
        #1 {ctrlWrEn, dataWrEn} = 2'b00;
    endtask
    task wt;
        n = 0;
        while (ctrlRd[6] !== 1'b0 && n < 5000) begin
            @(posedge clk);
            #1 n++;
        end
        repeat (2) @(posedge clk);
        #1;
    endtask
    task cmd(input logic [7:0] c, input logic [7:0] expCtrl);
        i0 = irqs;
        wr(1'b1, c);
        chk({7'h00, ctrlRd[6]}, 8'h01);
        wt();
        chk(8'(irqs - i0), 8'h01);
        chk(ctrlRd, expCtrl);
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    initial begin
        repeat (8) @(posedge clk);
        #1 rst_n = 1;
        repeat (4) @(posedge clk);
        chk(ctrlRd, 8'h30);
        chk(dataRd, 8'h00);
        chk({6'h00, sck, sckOe}, 8'h03);
        cmd(8'h09, 8'h30);
        chk({6'h00, sck, sdaOe}, 8'h03);
        wr(1'b1, 8'h00);
        wt();
        ack = 1;
        wr(1'b0, 8'hA5);
        cmd(8'h03, 8'h10);
        chk(sh[8:1], 8'hA5);
        ack = 0;
        cmd(8'h03, 8'h30);
        // idle toggling would shift the model's slot count, so stop the clock first
        wr(1'b1, 8'h00);
        wt();
        {rd, txByte} = {1'b1, 8'h3C};
        cmd(8'h02, 8'h20);
        chk({dataRd[7:1], sh[0]}, 8'h3C);
        wr(1'b1, 8'h00);
        wt();
        txByte = 8'hC3;
        cmd(8'h06, 8'h30);
        chk({dataRd[7:1], sh[0]}, 8'hC3);
        rd = 0;
        i0 = irqs;
        wr(1'b1, 8'h07);
        repeat (3) @(posedge clk);
        chk(ctrlRd, 8'hB0);
        chk(8'(irqs - i0), 8'h00);
        cmd(8'h05, 8'h30);
        chk({6'h00, sck, sdaOe}, 8'h02);
        sel = 2'h3;
        wr(1'b0, 8'hB0);
        cmd(8'h03, 8'h00);
        chk({5'h00, sh[2:0]}, 8'h05);
        chk({7'h00, sck}, 8'h00);
        cmd(8'h23, 8'h00);
        chk({7'h00, sdaOe}, 8'h00);
        // model moves data on falls, so the first slot reads the pull-up
        {rd, txByte} = {1'b1, 8'h50};
        cmd(8'h14, 8'h00);
        chk(dataRd, 8'h0A);
        cmd(8'h00, 8'h00);
        chk({7'h00, sdaOe}, 8'h01);
        hold = 1;
        i0 = irqs;
        wr(1'b1, 8'hA0);
        repeat (20) @(posedge clk);
        #1 chk({7'h00, ctrlRd[6]}, 8'h01);
        hold = 0;
        wt();
        chk(8'(irqs - i0), 8'h01);
        report_and_stop();
    end
endmodule
